// file: common/irq_flag_enable_pkg.sv
// constants and carrier types for the maskable interrupt flag and enable unit
package irq_flag_enable_pkg;

    // ****************************************************************
    // zero-page register map
    // ****************************************************************
    localparam logic [7:0] ADDR_FLAG_CLEAR  = 8'h10;
    localparam logic [7:0] ADDR_FLAGS       = 8'h11;
    localparam logic [7:0] ADDR_ENABLES     = 8'h12;
    localparam logic [7:0] ADDR_CNT_A_LOW   = 8'h18;
    localparam logic [7:0] ADDR_CNT_A_CLEAR = 8'h1a;
    localparam logic [7:0] ADDR_CNT_B_LOW   = 8'h1c;
    localparam logic [7:0] ADDR_CNT_B_CLEAR = 8'h1e;

    // ****************************************************************
    // reset and read values
    // ****************************************************************
    localparam logic [7:0] FLAGS_RESET      = 8'h00;
    localparam logic [7:0] ENABLES_RESET    = 8'h00;
    localparam logic [7:0] FLAG_CLEAR_READ  = 8'hff;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;
    localparam logic [3:0] PINS_RESET       = 4'h0;

    // ****************************************************************
    // flag positions
    // ****************************************************************
    localparam int FLAG_EDGE_RISE_0 = 0;
    localparam int FLAG_EDGE_RISE_1 = 1;
    localparam int FLAG_EDGE_FALL_2 = 2;
    localparam int FLAG_EDGE_FALL_3 = 3;
    localparam int FLAG_CNT_A       = 4;
    localparam int FLAG_CNT_B       = 5;
    localparam int FLAG_RECEIVER    = 6;
    localparam int FLAG_TRANSMITTER = 7;
    localparam logic [7:0] EDGE_FLAG_MASK = 8'h0f;

    // ****************************************************************
    // serial status positions
    // ****************************************************************
    localparam int SER_TX_IDLE_GATE = 5;
    localparam int SER_TX_READY     = 6;
    localparam int SER_TX_OTHER     = 7;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } bus_req_type;

    typedef struct packed {
        logic mask_clear_op;
        logic mask_set_op;
        logic software_break_op;
        logic return_from_handler_op;
        logic pull_status_op;
        logic nmi_taken;
        logic stacked_disable;
    } cpu_event_type;

endpackage

// file: hw/irq_flag_enable_unit.sv
// maskable interrupt flag and enable unit with the cpu interrupt-disable bit
`timescale 1ns/1ns

// Summary of operation
// - eight sources, each gated by own enable
// - request holds while any enabled flag pending
// - flags readable at 0011 at any time
// - 0010 reads ones; rmw result clears edges
// - edge set after rmw read survives
// - written one leaves edge flag alone
// - enables at 0012 written directly; reset clears
// - request when any flag and enable set
// - bits 0,1 set by rising pin edges
// - bits 2,3 set by falling pin edges
// - bit 4 counter a underflow, cleared 0018/001a
// - bit 5 counter b underflow, cleared 001c/001e
// - bit 6 is or of serial bits 0-3
// - request serviced only while disable bit clear
// - reset, irq or nmi set disable bit
// - instructions clear, set or reload disable bit
// - edges recognised at most once per two cycles
module irq_flag_enable_unit (
    input  wire logic                               clock_i,
    input  wire logic                               reset_i,
    input  wire irq_flag_enable_pkg::bus_req_type   bus_req_i,
    output logic [7:0]                              bus_rdata_o,
    input  wire logic [3:0]                         edge_pin_i,
    input  wire logic                               counter_a_underflow_i,
    input  wire logic                               counter_b_underflow_i,
    input  wire logic [7:0]                         serial_status_bits_i,
    input  wire irq_flag_enable_pkg::cpu_event_type cpu_event_i,
    output logic                                    irq_request_n_o,
    output logic                                    irq_accept_o,
    output logic                                    interrupt_disable_o,
    output logic [7:0]                              interrupt_flags_o,
    output logic [7:0]                              interrupt_enables_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] interrupt_flags_q;
    logic [7:0] interrupt_flags_d;
    logic [7:0] interrupt_enables_q;
    logic [7:0] interrupt_enables_d;
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    logic [7:0] bus_rdata_q;
    logic       irq_request_n_q;
    logic       irq_accept_q;
    logic       disable_q;
    logic       disable_d;
    logic [3:0] edge_seen;
    logic       take_irq;

    function automatic logic hit_rd(input irq_flag_enable_pkg::bus_req_type r, input logic [7:0] a);
        hit_rd = r.rd && (r.addr == {8'h00, a});
    endfunction

    function automatic logic hit_wr(input irq_flag_enable_pkg::bus_req_type r, input logic [7:0] a);
        hit_wr = r.wr && (r.addr == {8'h00, a});
    endfunction

    // ****************************************************************
    // edge detection
    // ****************************************************************
    // two flops then a previous sample; a level must hold one cycle to be seen
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_meta_q <= irq_flag_enable_pkg::PINS_RESET;
            pin_sync_q <= irq_flag_enable_pkg::PINS_RESET;
            pin_prev_q <= irq_flag_enable_pkg::PINS_RESET;
        end else begin
            pin_meta_q <= edge_pin_i;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    always_comb begin
        edge_seen[1:0] = pin_sync_q[1:0] & ~pin_prev_q[1:0];
        edge_seen[3:2] = ~pin_sync_q[3:2] & pin_prev_q[3:2];
    end
    // each transition needs high then low samples, so two cycles at least apart

    // ****************************************************************
    // flags
    // ****************************************************************
    always_comb begin
        interrupt_flags_d = interrupt_flags_q;
        // only the zero bits of the rmw result clear; ones are ignored
        if (hit_wr(bus_req_i, irq_flag_enable_pkg::ADDR_FLAGS)) begin
            interrupt_flags_d[3:0] = interrupt_flags_q[3:0] & bus_req_i.wdata[3:0];
        end
        // set after the clear so a fresh edge survives the write cycle
        interrupt_flags_d[3:0] = interrupt_flags_d[3:0] | edge_seen;
        if (hit_rd(bus_req_i, irq_flag_enable_pkg::ADDR_CNT_A_LOW) ||
            hit_wr(bus_req_i, irq_flag_enable_pkg::ADDR_CNT_A_CLEAR)) begin
            interrupt_flags_d[irq_flag_enable_pkg::FLAG_CNT_A] = 1'b0;
        end
        if (counter_a_underflow_i) begin
            interrupt_flags_d[irq_flag_enable_pkg::FLAG_CNT_A] = 1'b1;
        end
        if (hit_rd(bus_req_i, irq_flag_enable_pkg::ADDR_CNT_B_LOW) ||
            hit_wr(bus_req_i, irq_flag_enable_pkg::ADDR_CNT_B_CLEAR)) begin
            interrupt_flags_d[irq_flag_enable_pkg::FLAG_CNT_B] = 1'b0;
        end
        if (counter_b_underflow_i) begin
            interrupt_flags_d[irq_flag_enable_pkg::FLAG_CNT_B] = 1'b1;
        end
        // serial flags follow the status levels; cleared by clearing the status
        interrupt_flags_d[irq_flag_enable_pkg::FLAG_RECEIVER] = |serial_status_bits_i[3:0];
        interrupt_flags_d[irq_flag_enable_pkg::FLAG_TRANSMITTER] =
            (serial_status_bits_i[irq_flag_enable_pkg::SER_TX_READY] &
             ~serial_status_bits_i[irq_flag_enable_pkg::SER_TX_IDLE_GATE]) |
            serial_status_bits_i[irq_flag_enable_pkg::SER_TX_OTHER];
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            interrupt_flags_q <= irq_flag_enable_pkg::FLAGS_RESET;
        end else begin
            interrupt_flags_q <= interrupt_flags_d;
        end
    end

    // ****************************************************************
    // enables
    // ****************************************************************
    always_comb begin
        interrupt_enables_d = interrupt_enables_q;
        if (hit_wr(bus_req_i, irq_flag_enable_pkg::ADDR_ENABLES)) begin
            interrupt_enables_d = bus_req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            interrupt_enables_q <= irq_flag_enable_pkg::ENABLES_RESET;
        end else begin
            interrupt_enables_q <= interrupt_enables_d;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // answer registered; valid the cycle after the read strobe
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bus_rdata_q <= irq_flag_enable_pkg::UNMAPPED_READ;
        end else if (hit_rd(bus_req_i, irq_flag_enable_pkg::ADDR_FLAGS)) begin
            bus_rdata_q <= interrupt_flags_q;
        end else if (hit_rd(bus_req_i, irq_flag_enable_pkg::ADDR_FLAG_CLEAR)) begin
            bus_rdata_q <= irq_flag_enable_pkg::FLAG_CLEAR_READ;
        end else if (hit_rd(bus_req_i, irq_flag_enable_pkg::ADDR_ENABLES)) begin
            bus_rdata_q <= interrupt_enables_q;
        end else begin
            bus_rdata_q <= irq_flag_enable_pkg::UNMAPPED_READ;
        end
    end

    // ****************************************************************
    // combined request
    // ****************************************************************
    // built from next values so the pin tracks the registers without extra lag
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_request_n_q <= 1'b1;
        end else begin
            irq_request_n_q <= ~|(interrupt_flags_d & interrupt_enables_d);
        end
    end

    // ****************************************************************
    // interrupt-disable bit
    // ****************************************************************
    assign take_irq = ~irq_request_n_q & ~disable_q;

    always_comb begin
        disable_d = disable_q;
        if (take_irq || cpu_event_i.nmi_taken || cpu_event_i.mask_set_op ||
            cpu_event_i.software_break_op) begin
            disable_d = 1'b1;
        end else if (cpu_event_i.return_from_handler_op || cpu_event_i.pull_status_op) begin
            disable_d = cpu_event_i.stacked_disable;
        end else if (cpu_event_i.mask_clear_op) begin
            disable_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            disable_q    <= 1'b1;
            irq_accept_q <= 1'b0;
        end else begin
            disable_q    <= disable_d;
            irq_accept_q <= take_irq;
        end
    end

    assign bus_rdata_o         = bus_rdata_q;
    assign irq_request_n_o     = irq_request_n_q;
    assign irq_accept_o        = irq_accept_q;
    assign interrupt_disable_o = disable_q;
    assign interrupt_flags_o   = interrupt_flags_q;
    assign interrupt_enables_o = interrupt_enables_q;

endmodule

// file: tb/cpu_core_model.sv
// cpu core stand-in: turns a bench opcode into one event pulse
`timescale 1ns/1ns
module cpu_core_model (
    input  wire logic                            clock_i,
    input  wire logic                            reset_i,
    input  wire logic [2:0]                      op_i,
    input  wire logic                            stacked_i,
    output irq_flag_enable_pkg::cpu_event_type   cpu_event_o
);
    // op 1..6 picks clear, set, break, return, pull, nmi
    always_ff @(posedge clock_i) begin
        cpu_event_o <= '0;
        if (!reset_i && op_i != 3'h0) begin
            cpu_event_o[3'd7 - op_i] <= 1'b1;
        end
        cpu_event_o.stacked_disable <= stacked_i;
    end
endmodule

// file: tb/irq_flag_enable_properties.sv
// checker for the interrupt flag and enable unit ports
`timescale 1ns/1ns
module irq_flag_enable_checker (
    input wire logic                               clock_i,
    input wire logic                               reset_i,
    input wire irq_flag_enable_pkg::bus_req_type   bus_req_i,
    input wire logic [7:0]                         bus_rdata_o,
    input wire logic [3:0]                         edge_pin_i,
    input wire logic                               counter_a_underflow_i,
    input wire logic                               counter_b_underflow_i,
    input wire logic [7:0]                         serial_status_bits_i,
    input wire irq_flag_enable_pkg::cpu_event_type cpu_event_i,
    input wire logic                               irq_request_n_o,
    input wire logic                               irq_accept_o,
    input wire logic                               interrupt_disable_o,
    input wire logic [7:0]                         interrupt_flags_o,
    input wire logic [7:0]                         interrupt_enables_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence rise_0_s; $rose(edge_pin_i[0]); endsequence
    sequence flag_0_s; ##[1:4] interrupt_flags_o[0]; endsequence
    AST_REQ_COMBINE: assert property (irq_request_n_o == ~|(interrupt_flags_o & interrupt_enables_o))
        else $error("request does not match flags and enables");
    AST_ACCEPT_CAUSE: assert property (irq_accept_o |-> !$past(irq_request_n_o) && !$past(interrupt_disable_o)
        && interrupt_disable_o) else $error("accept without cause");
    AST_ACCEPT_TAKEN: assert property (!irq_request_n_o && !interrupt_disable_o |=> irq_accept_o)
        else $error("open request not taken");
    AST_CLEAR_READ: assert property (bus_req_i.rd && bus_req_i.addr == 16'h0010 |=> bus_rdata_o == 8'hff)
        else $error("clear address not read as ones");
    AST_FLAG_READ: assert property (bus_req_i.rd && bus_req_i.addr == 16'h0011
        |=> bus_rdata_o == $past(interrupt_flags_o)) else $error("flag read wrong");
    AST_ENABLE_WRITE: assert property (bus_req_i.wr && bus_req_i.addr == 16'h0012
        |=> interrupt_enables_o == $past(bus_req_i.wdata)) else $error("enable write lost");
    AST_EDGE_ONE: assert property (bus_req_i.wr && bus_req_i.addr == 16'h0011
        |=> ($past(interrupt_flags_o[3:0]) & $past(bus_req_i.wdata[3:0]) & ~interrupt_flags_o[3:0]) == 4'h0)
        else $error("written one cleared an edge flag");
    AST_CNT_A: assert property (counter_a_underflow_i |=> interrupt_flags_o[4])
        else $error("underflow flag not set");
    AST_RX_FLAG: assert property (!$past(reset_i) |-> interrupt_flags_o[6] == (|$past(serial_status_bits_i[3:0])))
        else $error("receiver flag wrong");
    AST_RISE_0: assert property (rise_0_s |-> flag_0_s) else $error("rising edge missed");
endmodule
bind irq_flag_enable_unit irq_flag_enable_checker chk_u (.clock_i, .reset_i, .bus_req_i, .bus_rdata_o, .edge_pin_i,
    .counter_a_underflow_i, .counter_b_underflow_i, .serial_status_bits_i, .cpu_event_i, .irq_request_n_o,
    .irq_accept_o, .interrupt_disable_o, .interrupt_flags_o, .interrupt_enables_o);

// file: tb/irq_flag_enable_unit_tb.sv
// self-checking bench for the interrupt flag and enable unit
`timescale 1ns/1ns
module irq_flag_enable_unit_tb;
    logic                               clock_i, reset_i, stacked, seen;
    logic                               irq_request_n_o, irq_accept_o, interrupt_disable_o;
    logic [1:0]                         underflow;
    logic [2:0]                         op;
    logic [3:0]                         edge_pin_i;
    logic [7:0]                         serial_status_bits_i, bus_rdata_o, interrupt_flags_o, interrupt_enables_o;
    irq_flag_enable_pkg::bus_req_type   bus_req_i;
    irq_flag_enable_pkg::cpu_event_type cpu_event_i;
    logic [7:0]                         ser_tab [4] = '{8'h01, 8'h40, 8'h60, 8'h88};
    logic [7:0]                         ser_exp [4] = '{8'h40, 8'h80, 8'h00, 8'hc0};
    logic [2:0]                         op_tab [8] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h5, 3'h4, 3'h1, 3'h6};
    logic                               dis_tab [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int                                 num_errors = 0, total_checks = 0, i;

    irq_flag_enable_unit dut_u (.clock_i, .reset_i, .bus_req_i, .bus_rdata_o, .edge_pin_i,
        .counter_a_underflow_i(underflow[0]), .counter_b_underflow_i(underflow[1]), .serial_status_bits_i,
        .cpu_event_i, .irq_request_n_o, .irq_accept_o, .interrupt_disable_o, .interrupt_flags_o, .interrupt_enables_o);
    cpu_core_model cpu_u (.clock_i, .reset_i, .op_i(op), .stacked_i(stacked), .cpu_event_o(cpu_event_i));

    // ****************************************************************
    // bus and cpu tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        pause(1);
        bus_req_i = '{{8'h00, a}, d, !w, w};
        pause(1);
        bus_req_i = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        access(a, 8'h00, 1'b0);
        check(bus_rdata_o, exp);
    endtask
    // read then write on back-to-back cycles, as the bit-clear op does
    task automatic rmw(input int n);
        pause(1);
        bus_req_i = '{16'h0010, 8'h00, 1'b1, 1'b0};
        pause(1);
        check(bus_rdata_o, 8'hff);
        bus_req_i = '{16'h0011, ~(8'h01 << n), 1'b0, 1'b1};
        pause(1);
        bus_req_i = '0;
    endtask
    task automatic cpu(input logic [2:0] v, input logic s);
        seen = 1'b0;
        pause(1);
        op = v;
        stacked = s;
        pause(1);
        op = 3'h0;
        repeat (3) begin
            pause(1);
            seen |= irq_accept_o;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // whole run is about 130 cycles
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
    initial begin
        reset_i = 1'b1;
        bus_req_i = '0;
        edge_pin_i = 4'h0;
        underflow = 2'b00;
        serial_status_bits_i = 8'h00;
        op = 3'h0;
        stacked = 1'b0;
        pause(2);
        reset_i = 1'b0;
        check(interrupt_disable_o, 8'h01);
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h00);
        rd(8'h10, 8'hff);
        rd(8'h05, 8'h00);
        $display("test registers done");
        access(8'h12, 8'hff, 1'b1);
        edge_pin_i = 4'hc;
        pause(5);
        check(interrupt_flags_o, 8'h00);
        edge_pin_i = 4'h3;
        pause(5);
        check(interrupt_flags_o, 8'h0f);
        check(irq_request_n_o, 8'h00);
        access(8'h11, 8'hff, 1'b1);
        rmw(0);
        rmw(1);
        check(interrupt_flags_o, 8'h0c);
        edge_pin_i = 4'h1;
        pause(5);
        // the new edge reaches the flag logic in the write cycle of the clear
        edge_pin_i = 4'h3;
        rmw(1);
        check(interrupt_flags_o, 8'h0e);
        rmw(1);
        rmw(2);
        check(irq_request_n_o, 8'h00);
        rmw(3);
        check(irq_request_n_o, 8'h01);
        $display("test edges done");
        for (i = 0; i < 4; i++) begin
            underflow[i / 2] = 1'b1;
            pause(1);
            underflow = 2'b00;
            pause(1);
            check(interrupt_flags_o, 8'h10 << (i / 2));
            access(8'h18 + 8'(4 * (i / 2)) + 8'(2 * (i % 2)), 8'h00, 1'(i % 2));
            check(interrupt_flags_o, 8'h00);
        end
        for (i = 0; i < 4; i++) begin
            serial_status_bits_i = ser_tab[i];
            pause(2);
            check(interrupt_flags_o, ser_exp[i]);
        end
        serial_status_bits_i = 8'h01;
        access(8'h12, 8'hbf, 1'b1);
        check(irq_request_n_o, 8'h01);
        access(8'h12, 8'h40, 1'b1);
        check(irq_request_n_o, 8'h00);
        $display("test sources done");
        cpu(3'h0, 1'b0);
        check(seen, 8'h00);
        access(8'h12, 8'h00, 1'b1);
        for (i = 0; i < 8; i++) begin
            cpu(op_tab[i], dis_tab[i]);
            check(interrupt_disable_o, dis_tab[i]);
        end
        access(8'h12, 8'h40, 1'b1);
        cpu(3'h1, 1'b0);
        check(seen, 8'h01);
        check(interrupt_disable_o, 8'h01);
        $display("test cpu done");
        stop_test();
    end
endmodule
